/* File: inc/wdrs_pkg.sv */
// types shared by the watchdog and reset source design files
// assumes wdrs_regs.svh is on the include path
package wdrs_pkg;
    typedef enum logic [2:0] {
        WDRS_IDLE  = 3'b000,
        WDRS_PULSE = 3'b001,
        WDRS_SEQ   = 3'b010,
        WDRS_EXTEND= 3'b011,
        WDRS_LATCH = 3'b100
    } wdrs_state_t;
    typedef enum logic [1:0] {
        WDRS_SRC_SHORT = 2'b00,
        WDRS_SRC_SOFT  = 2'b01,
        WDRS_SRC_WDOG  = 2'b10
    } wdrs_src_t;
endpackage

/* File: inc/wdrs_regs.svh */
// register offsets, field positions, divider values and timing counts for the watchdog block
// assumes inclusion by bare name from the design and verification files
`ifndef WDRS_REGS_SVH
`define WDRS_REGS_SVH
`define WDRS_OFF_CONTROL     16'hFFAE
`define WDRS_OFF_IRQ_STATUS  16'hFFB0
`define WDRS_OFF_IRQ_MASK    16'hFFB2
`define WDRS_OFF_MISC        16'hFFB4
`define WDRS_BIT_CLKSEL      0
`define WDRS_BIT_WDT         1
`define WDRS_BIT_SWR         2
`define WDRS_BIT_SHORT_HW_RESET_FLAG        3
`define WDRS_BIT_LONG_HW_RESET_FLAG        4
`define WDRS_BIT_POWER_ON_FLAG        5
`define WDRS_REL_LSB         8
`define WDRS_DIV_SLOW        7'h7F
`define WDRS_DIV_FAST        7'h01
`define WDRS_TCL_MIN_DETECT  4
`define WDRS_TCL_SHORT_MAX   1038
`define WDRS_TCL_LONG_MIN    1040
`define WDRS_TCL_SEQ         1024
`define WDRS_TCL_LATCH_BYP   6
`define WDRS_TCL_LATCH_NORM  8
`define WDRS_CYC(half_clock_period)        ((half_clock_period) / 2)
`endif

/* File: rtl/wdrs_prescaler.sv */
// prescaler producing one-cycle ticks at cpu clock over 2 or over 128
// assumes a single clock domain and synchronous active-high reset
`timescale 1ns/1ps
module wdrs_prescaler
    import wdrs_pkg::*;
(
    input  wire logic clock,    // cpu clock
    input  wire logic rst,      // synchronous reset
    input  wire logic restart,  // zero the divider on service
    input  wire logic slow_sel, // 1 selects divide by 128
    output logic      tick      // one-cycle count enable
);
`include "wdrs_regs.svh"
    logic [6:0] div_r;          // free divider count
    logic [6:0] div_top;        // terminal count for the chosen rate

    // terminal value from the clock select bit
    assign div_top = slow_sel ? `WDRS_DIV_SLOW : `WDRS_DIV_FAST;

    always_ff @(posedge clock) begin
        if (rst || restart || div_r >= div_top) begin
            div_r <= 7'h00;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    // tick on the terminal count, so one tick per 2 or 128 clocks
    always_ff @(posedge clock) begin
        if (rst || restart) begin
            tick <= 1'b0;
        end else begin
            tick <= (div_r >= div_top);
        end
    end
endmodule

/* File: rtl/wdrs_watchdog.sv */
// watchdog counter, reset source classifier and reset indication flags
// assumes reset_in_pin and reset_mode_pin are synchronous; instructions arrive as
// one-cycle strobes from the cpu core; register port answers reads one cycle later
`timescale 1ns/1ps
`include "wdrs_regs.svh"
module wdrs_watchdog
    import wdrs_pkg::*;
#(
    parameter int SEQ_CYC = `WDRS_CYC(`WDRS_TCL_SEQ)  // internal sequence length
)
(
    input  wire logic        clock,            // cpu clock, 100 MHz
    input  wire logic        rst,              // synchronous reset, active high
    input  wire logic [15:0] reg_addr,         // register address
    input  wire logic [15:0] reg_wdata,        // register write data
    input  wire logic        reg_wr,           // write strobe
    input  wire logic        reg_rd,           // read strobe
    output logic      [15:0] reg_rdata,        // read data, cycle after strobe
    input  wire logic        end_of_init_instr,      // end-of-init executed
    input  wire logic        service_watchdog_instr, // service executed
    input  wire logic        software_reset_instr,   // software reset executed
    input  wire logic        disable_watchdog_instr, // disable request
    input  wire logic        power_on_detect,  // power-on detector level
    input  wire logic        bidir_reset_en,   // bidirectional reset enabled
    input  wire logic        pll_bypass_presc, // pll bypassed with prescaler on
    input  wire logic        reset_in_pin_n,   // reset input pin, active low
    input  wire logic        reset_mode_pin,   // low async, high sync
    output logic             reset_out_pin_n,  // reset output pin, active low
    output logic             reset_in_pull_n,  // pull reset input low
    output logic             internal_reset,   // core held in reset
    output logic             force_bus_idle,   // abort bus, tristate, port0 high
    output logic             async_mode,       // reset mode sampled while the reset input is low
    output logic             config_latch,     // one-cycle port0 latch strobe
    output logic             irq               // level interrupt
);
    localparam int MIN_CYC   = `WDRS_CYC(`WDRS_TCL_MIN_DETECT);
    localparam int SHORT_CYC = `WDRS_CYC(`WDRS_TCL_SHORT_MAX);
    localparam int LONG_CYC  = `WDRS_CYC(`WDRS_TCL_LONG_MIN);
    localparam int LATB_CYC  = `WDRS_CYC(`WDRS_TCL_LATCH_BYP);
    localparam int LATN_CYC  = `WDRS_CYC(`WDRS_TCL_LATCH_NORM);

    wdrs_state_t state_r;           // reset sequencer state
    wdrs_src_t   src_r;             // what started the sequence
    logic [15:0] cnt_r;             // watchdog counter
    logic [7:0]  reload_r;          // reload value field
    logic        clk_sel_r;         // input clock select
    logic        enabled_r;         // watchdog running
    logic        init_done_r;       // end-of-init seen
    logic        wdt_flag_r;        // watchdog reset flag
    logic        swr_flag_r;        // software reset flag
    logic        short_hw_reset_flag_flag_r;       // short hw reset flag
    logic        long_hw_reset_flag_flag_r;       // long hw reset flag
    logic        pon_flag_r;        // power-on flag
    logic        pon_seen_r;        // detector seen during this reset
    logic        long_hw_reset_flag_seen_r;       // sequence went through extension or saw power-on
    logic [15:0] tmr_r;             // sequence timer
    logic [15:0] pulse_r;           // reset input low length
    logic [5:0]  irq_stat_r;        // sticky event bits
    logic [5:0]  irq_mask_r;        // interrupt enables
    logic        tick;              // prescaled count enable
    logic        overflow;          // counter wraps this cycle
    logic        in_low;            // reset input asserted
    logic        wr_ctl;            // control register write
    logic [5:0]  ev;                // event pulses
    logic [15:0] ctl_view;          // control register read image

    // decode one register address, used by both write and read paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // long classification: extended sequence or power-on
    function automatic logic long_hw_reset_flag_nxt();
        long_hw_reset_flag_nxt = long_hw_reset_flag_seen_r || pon_seen_r;
    endfunction

    assign in_low = ~reset_in_pin_n;
    assign wr_ctl = reg_wr && hit(reg_addr, `WDRS_OFF_CONTROL);
    assign overflow = enabled_r && tick && (cnt_r == 16'hFFFF) && (state_r == WDRS_IDLE);

    wdrs_prescaler u_presc (
        .clock    (clock),
        .rst      (rst || internal_reset),
        .restart  (service_watchdog_instr),
        .slow_sel (clk_sel_r),
        .tick     (tick)
    );

    // control fields; flags are not writable so only select and reload store
    // software rewrites control, we simply accept any write
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_sel_r <= 1'b0;
            reload_r  <= 8'h00;
        end else if (wr_ctl) begin
            clk_sel_r <= reg_wdata[`WDRS_BIT_CLKSEL];
            reload_r  <= reg_wdata[15:`WDRS_REL_LSB];
        end
    end

    // enable and init tracking; a disable after init is ignored
    always_ff @(posedge clock) begin
        if (rst || internal_reset) begin
            enabled_r   <= 1'b1;
            init_done_r <= 1'b0;
        end else begin
            if (end_of_init_instr) begin
                init_done_r <= 1'b1;
            end
            if (disable_watchdog_instr && !init_done_r && !end_of_init_instr) begin
                enabled_r <= 1'b0;
            end
        end
    end

    // counter: held during reset, reloads on service, counts on ticks
    always_ff @(posedge clock) begin
        if (rst || internal_reset) begin
            cnt_r <= 16'h0000;
        end else if (service_watchdog_instr) begin
            cnt_r <= {reload_r, 8'h00};
        end else if (enabled_r && tick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // reset input low length; saturates well past the long threshold
    always_ff @(posedge clock) begin
        if (rst || !in_low) begin
            pulse_r <= 16'h0000;
        end else if (pulse_r != 16'hFFFF) begin
            pulse_r <= pulse_r + 16'h0001;
        end
    end

    // mode pin sampled while input low
    always_ff @(posedge clock) begin
        if (rst) begin
            async_mode <= 1'b0;
        end else if (in_low) begin
            async_mode <= ~reset_mode_pin;
        end
    end

    // power-on detector level caught while the sequence runs
    always_ff @(posedge clock) begin
        if (rst || state_r == WDRS_IDLE) begin
            pon_seen_r <= 1'b0;
        end else if (power_on_detect) begin
            pon_seen_r <= 1'b1;
        end
    end

    // reset sequencer: pulse qualify, internal sequence, extension, port0 latch
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= WDRS_IDLE;
            src_r   <= WDRS_SRC_SHORT;
            tmr_r   <= 16'h0000;
        end else begin
            case (state_r)
                WDRS_IDLE: begin
                    tmr_r <= 16'h0000;
                    if (overflow) begin
                        state_r <= WDRS_SEQ;
                        src_r   <= WDRS_SRC_WDOG;
                    end else if (software_reset_instr) begin
                        state_r <= WDRS_SEQ;
                        src_r   <= WDRS_SRC_SOFT;
                    end else if (in_low) begin
                        state_r <= WDRS_PULSE;
                        src_r   <= WDRS_SRC_SHORT;
                    end
                end
                WDRS_PULSE: begin
                    if (!in_low) begin
                        state_r <= WDRS_IDLE;
                    end else if (pulse_r >= 16'(MIN_CYC - 1)) begin
                        state_r <= WDRS_SEQ;
                    end
                end
                WDRS_SEQ: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_r >= 16'(SEQ_CYC - 1)) begin
                        tmr_r   <= 16'h0000;
                        state_r <= in_low ? WDRS_EXTEND : WDRS_LATCH;
                    end
                end
                WDRS_EXTEND: begin
                    if (!in_low) begin
                        state_r <= WDRS_LATCH;
                    end
                end
                WDRS_LATCH: begin
                    tmr_r <= tmr_r + 16'h0001;
                    // latch after 6 or 8 half periods
                    if (tmr_r >= 16'(pll_bypass_presc ? LATB_CYC - 1 : LATN_CYC - 1)) begin
                        state_r <= WDRS_IDLE;
                    end
                end
                default: begin
                    state_r <= WDRS_IDLE;
                end
            endcase
        end
    end

    // internal reset and output low while sequencing
    assign internal_reset  = (state_r != WDRS_IDLE) && (state_r != WDRS_PULSE);
    assign reset_out_pin_n = rst ? 1'b0 : ~(internal_reset || (state_r == WDRS_PULSE && in_low));
    // pull released on the last sequence cycle, so the sample sees only the far side
    assign reset_in_pull_n = ~(bidir_reset_en && state_r == WDRS_SEQ &&
                               tmr_r < 16'(SEQ_CYC - 1));
    assign config_latch    = (state_r == WDRS_LATCH) &&
                             (tmr_r == 16'(pll_bypass_presc ? LATB_CYC - 1 : LATN_CYC - 1));
    // long pulse forces pins at once
    assign force_bus_idle  = internal_reset || (state_r == WDRS_PULSE) ||
                             (in_low && pulse_r >= 16'(LONG_CYC - 1));

    // reset indication flags, set at end of sequence, cleared by init except the watchdog flag, which service clears
    // no software write path
    always_ff @(posedge clock) begin
        if (rst) begin
            wdt_flag_r  <= 1'b0;
            swr_flag_r  <= 1'b0;
            short_hw_reset_flag_flag_r <= 1'b0;
            long_hw_reset_flag_flag_r <= 1'b0;
            pon_flag_r  <= 1'b0;
        end else if (config_latch) begin
            swr_flag_r  <= 1'b1;
            wdt_flag_r  <= (src_r == WDRS_SRC_WDOG) && (pulse_r == 16'h0000) && !long_hw_reset_flag_nxt();
            short_hw_reset_flag_flag_r <= (src_r == WDRS_SRC_SHORT) || long_hw_reset_flag_nxt();
            long_hw_reset_flag_flag_r <= long_hw_reset_flag_nxt();
            pon_flag_r  <= pon_seen_r;
        end else begin
            if (service_watchdog_instr) begin
                wdt_flag_r <= 1'b0;
            end
            if (end_of_init_instr) begin
                swr_flag_r  <= 1'b0;
                short_hw_reset_flag_flag_r <= 1'b0;
                long_hw_reset_flag_flag_r <= 1'b0;
                pon_flag_r  <= 1'b0;
            end
        end
    end

    // sticky record that the sequence went through extension or saw power-on
    always_ff @(posedge clock) begin
        if (rst || state_r == WDRS_IDLE) begin
            long_hw_reset_flag_seen_r <= 1'b0;
        end else if (state_r == WDRS_EXTEND || power_on_detect) begin
            long_hw_reset_flag_seen_r <= 1'b1;
        end
    end

    // events into the sticky status: one bit per flag position
    assign ev = {6'h00} | ({config_latch && pon_seen_r, config_latch && long_hw_reset_flag_nxt(),
                 config_latch, config_latch, overflow, service_watchdog_instr});

    // sticky interrupt status; set wins over a write-one clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat_r <= 6'h00;
            irq_mask_r <= 6'h00;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((reg_wr && hit(reg_addr, `WDRS_OFF_IRQ_STATUS))
                          ? reg_wdata[5:0] : 6'h00)) | ev;
            if (reg_wr && hit(reg_addr, `WDRS_OFF_IRQ_MASK)) begin
                irq_mask_r <= reg_wdata[5:0];
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // control register image; bits 7:6 read zero
    assign ctl_view = {reload_r, 2'b00, pon_flag_r, long_hw_reset_flag_flag_r, short_hw_reset_flag_flag_r,
                       swr_flag_r, wdt_flag_r, clk_sel_r};

    // read data registered one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (hit(reg_addr, `WDRS_OFF_CONTROL)) begin
            reg_rdata <= ctl_view;
        end else if (hit(reg_addr, `WDRS_OFF_IRQ_STATUS)) begin
            reg_rdata <= {10'h000, irq_stat_r};
        end else if (hit(reg_addr, `WDRS_OFF_IRQ_MASK)) begin
            reg_rdata <= {10'h000, irq_mask_r};
        end else if (hit(reg_addr, `WDRS_OFF_MISC)) begin
            reg_rdata <= {13'h0000, init_done_r, enabled_r, async_mode};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

/* File: verif/test_watchdog_and_reset_source_flags.sv */
// self-checking bench for the watchdog and reset source block
// assumes the reset circuit model drives the reset input pin; reads checked from a queue
`timescale 1ns/1ps
`include "wdrs_regs.svh"
module test_watchdog_and_reset_source_flags;
    localparam int SEQ = 16; // shortened sequence keeps the run short
    logic        clock = 1'b0;        // cpu clock
    logic        rst = 1'b1;          // synchronous reset
    logic [15:0] reg_addr = 16'h0000; // register address
    logic [15:0] reg_wdata = 16'h0000; // write data
    logic        reg_wr = 1'b0;       // write strobe
    logic        reg_rd = 1'b0;       // read strobe
    logic [3:0]  ins_r = 4'h0;        // init, service, software_reset_instr, disable
    logic        pon = 1'b0;          // power-on detector
    logic        bidir = 1'b0;        // bidirectional reset enable
    logic        pll = 1'b0;          // pll bypass with prescaler
    logic        mode = 1'b1;         // reset mode pin
    logic        go = 1'b0;           // start an external pulse
    logic [15:0] len = 16'h0000;      // external pulse length
    logic [15:0] reg_rdata, d;        // read data, random write value
    logic        pin_n, pull_n, out_n, intr, idle, latch, irq; // resolved pin from the reset circuit model, then design outputs
    logic        rd_seen = 1'b0;      // read answer due this edge
    logic [31:0] e, exp_q[$];         // mask and expected read data
    int          err_count = 0;       // mismatches
    int          cmp_count = 0;       // comparisons
    always #5 clock = ~clock;
    wdrs_watchdog #(.SEQ_CYC(SEQ)) u_dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .end_of_init_instr(ins_r[0]), .service_watchdog_instr(ins_r[1]),
        .software_reset_instr(ins_r[2]), .disable_watchdog_instr(ins_r[3]),
        .power_on_detect(pon), .bidir_reset_en(bidir), .pll_bypass_presc(pll),
        .reset_in_pin_n(pin_n), .reset_mode_pin(mode), .reset_out_pin_n(out_n),
        .reset_in_pull_n(pull_n), .internal_reset(intr), .force_bus_idle(idle),
        .async_mode(), .config_latch(latch), .irq(irq));
    wdrs_reset_circuit u_ext (.clock(clock), .go(go), .len(len),
        .reset_in_pull_n(pull_n), .reset_in_pin_n(pin_n));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the answer is due one edge after the strobe edge, and only then
    always @(posedge clock) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            chk(reg_rdata & e[31:16], e[15:0]);
        end
        rd_seen <= reg_rd;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // a gap cycle after each strobe avoids two assignments in one step
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] x);
        exp_q.push_back({m, x});
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
    endtask
    task automatic ins(input int k);
        ins_r[k] <= 1'b1;
        cyc(1);
        ins_r <= 4'h0;
        cyc(1);
    endtask
    task automatic arm(input logic [15:0] c);
        wr(`WDRS_OFF_CONTROL, c);
        ins(1);
    endtask
    task automatic wait_latch();
        int n;
        n = 0;
        while (latch !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        if (n >= 5000) begin
            err_count++;
            conclude();
        end
        cyc(2);
    endtask
    // flags after one reset, then after end of init all five flag bits must read zero
    task automatic flags(input logic [15:0] x);
        rd(`WDRS_OFF_CONTROL, 16'h003E, x);
        ins(0);
        rd(`WDRS_OFF_CONTROL, 16'h003E, 16'h0000);
    endtask
    task automatic timeout(input logic [15:0] c, input int exp);
        int n;
        arm(c);
        n = 1;
        while (intr !== 1'b1 && n < 40000) begin
            cyc(1);
            n++;
        end
        cmp_count++;
        if (n < exp - 4 || n > exp + 4) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, n, exp);
        end
        wait_latch();
        rd(`WDRS_OFF_CONTROL, 16'h003E, 16'h0006);
        arm(16'h0000);
        flags(16'h0004);
    endtask
    task automatic pin_case(input logic [15:0] l, input logic p, input logic s,
                            input logic [15:0] x);
        pon <= p;
        bidir <= s;
        pll <= 1'($urandom);
        mode <= 1'($urandom);
        len <= l;
        if (s) ins(2);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(8);
        chk({15'h0000, out_n}, 16'h0000);
        if (l > SEQ && !s) chk({15'h0000, idle}, 16'h0001);
        wait_latch();
        rd(`WDRS_OFF_MISC, 16'h0001, {15'h0000, ~mode});
        pon <= 1'b0;
        bidir <= 1'b0;
        flags(x);
    endtask
    initial begin
        void'($urandom(32'h9D6A3527));
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        rd(`WDRS_OFF_CONTROL, 16'hFF01, 16'h0000);
        rd(16'hFFB6, 16'hFFFF, 16'h0000);
        ins(3);
        rd(`WDRS_OFF_MISC, 16'h0002, 16'h0000);
        ins(2);
        wait_latch();
        rd(`WDRS_OFF_MISC, 16'h0002, 16'h0002);
        flags(16'h0004);
        ins(3);
        rd(`WDRS_OFF_MISC, 16'h0002, 16'h0002);
        d = 16'($urandom);
        wr(`WDRS_OFF_CONTROL, d);
        rd(`WDRS_OFF_CONTROL, 16'hFF3F, d & 16'hFF01);
        $display("registers done");
        wr(`WDRS_OFF_IRQ_MASK, 16'h0000);
        arm(16'h0000);
        rd(`WDRS_OFF_IRQ_STATUS, 16'h0001, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        wr(`WDRS_OFF_IRQ_MASK, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr(`WDRS_OFF_IRQ_STATUS, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        $display("interrupt done");
        timeout(16'hFF00, 512);
        timeout(16'hFE00, 1024);
        timeout(16'hFF01, 32768);
        $display("timeout done");
        pin_case(16'(3 + $urandom % 10), 1'b0, 1'b0, 16'h000C);
        pin_case(16'(SEQ + 20), 1'b0, 1'b0, 16'h001C);
        pin_case(16'h0008, 1'b1, 1'b0, 16'h003C);
        pin_case(16'(SEQ + 20), 1'b0, 1'b1, 16'h001C);
        pin_case(16'h0004, 1'b0, 1'b1, 16'h0004);
        $display("reset sources done");
        conclude();
    end
endmodule

/* File: verif/wdrs_reset_circuit.sv */
// model of the external reset circuitry on the reset input pin
// assumes a pull-up on the pin and the device pull-down as a second open-drain party
`timescale 1ns/1ps
module wdrs_reset_circuit (
    input  wire logic        clock,           // cpu clock
    input  wire logic        go,              // start one low pulse
    input  wire logic [15:0] len,             // pulse length in clock cycles
    input  wire logic        reset_in_pull_n, // device pull-down, active low
    output logic             reset_in_pin_n   // resolved pin level
);
    logic [15:0] left_r = 16'h0000; // cycles of low drive still to come

    // pulse length decides short or long
    always_ff @(posedge clock) begin
        if (go) begin
            left_r <= len;
        end else if (left_r != 16'h0000) begin
            left_r <= left_r - 16'h0001;
        end
    end

    // wired-and: either party pulls low, else the pull-up wins
    assign reset_in_pin_n = (left_r == 16'h0000) && reset_in_pull_n;
endmodule

/* File: verif/wdrs_watchdog_props.sv */
// concurrent checks on the ports of the watchdog and reset source block
// assumes one clock and the synchronous active-high block reset
`timescale 1ns/1ps
`include "wdrs_regs.svh"
module wdrs_watchdog_props
    import wdrs_pkg::*;
#(
    parameter int SEQ_CYC = 512 // internal sequence length
)
(
    input wire logic        clock,           // cpu clock
    input wire logic        rst,             // synchronous reset
    input wire logic [15:0] reg_addr,        // register address
    input wire logic        reg_rd,          // read strobe
    input wire logic [15:0] reg_rdata,       // read data
    input wire logic        reset_in_pin_n,  // reset input pin
    input wire logic        reset_in_pull_n, // device pull on the pin
    input wire logic        reset_out_pin_n, // reset output pin
    input wire logic        internal_reset,  // core held in reset
    input wire logic        config_latch     // port0 latch strobe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [15:0] ir_cnt_r; // consecutive cycles of internal reset
    wire logic   mapped;   // address decodes to a register
    assign mapped = (reg_addr == `WDRS_OFF_CONTROL) || (reg_addr == `WDRS_OFF_IRQ_STATUS)
                 || (reg_addr == `WDRS_OFF_IRQ_MASK) || (reg_addr == `WDRS_OFF_MISC);
    // saturating count, so a stuck reset never wraps back into range
    always_ff @(posedge clock) begin
        if (rst || !internal_reset) begin
            ir_cnt_r <= 16'h0000;
        end else if (ir_cnt_r != 16'hFFFF) begin
            ir_cnt_r <= ir_cnt_r + 16'h0001;
        end
    end
    sequence pin_low2;
        !reset_in_pin_n [*2];
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside answer cycle");
    chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    chk_out_follows: assert property (internal_reset |-> !reset_out_pin_n)
        else $error("reset output high during internal reset");
    chk_pin_to_out: assert property (pin_low2 |-> ##[0:6] !reset_out_pin_n)
        else $error("reset output not driven low after input low");
    chk_seq_length: assert property ($fell(internal_reset) |-> ir_cnt_r >= 16'(SEQ_CYC))
        else $error("internal reset shorter than the sequence");
    chk_latch_after_rise: assert property (config_latch |-> reset_in_pin_n && $past(reset_in_pin_n, 2))
        else $error("configuration latched too soon after input rise");
    chk_latch_pulse: assert property (config_latch |=> !config_latch)
        else $error("latch strobe longer than one cycle");
    chk_pull_in_reset: assert property (!reset_in_pull_n |-> internal_reset)
        else $error("pin pulled low outside a reset sequence");
endmodule

bind wdrs_watchdog wdrs_watchdog_props #(.SEQ_CYC(SEQ_CYC)) u_props (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_in_pin_n(reset_in_pin_n), .reset_in_pull_n(reset_in_pull_n),
    .reset_out_pin_n(reset_out_pin_n), .internal_reset(internal_reset),
    .config_latch(config_latch));
